// ---- src/uil_pkg.sv ----
// package: register map, field layout and timing constants of the uart interrupt logic
package uil_pkg;
  // register byte offsets
  localparam logic [7:0] UIL_OFS_RAW = 8'h00;
  localparam logic [7:0] UIL_OFS_MASK = 8'h04;
  localparam logic [7:0] UIL_OFS_MIS = 8'h08;
  localparam logic [7:0] UIL_OFS_CLR = 8'h0c;
  localparam logic [7:0] UIL_OFS_LVL = 8'h10;
  localparam logic [7:0] UIL_OFS_CTL = 8'h14;
  // event bit positions
  localparam int UIL_NEV = 7;
  localparam int UIL_B_RX = 0;
  localparam int UIL_B_TX = 1;
  localparam int UIL_B_RTO = 2;
  localparam int UIL_B_FE = 3;
  localparam int UIL_B_PE = 4;
  localparam int UIL_B_BE = 5;
  localparam int UIL_B_OE = 6;
  // level select field: tx in [2:0], rx in [5:3]
  localparam int UIL_LVL_W = 3;
  localparam int UIL_TXL_LSB = 0;
  localparam int UIL_RXL_LSB = 3;
  localparam logic [5:0] UIL_LVL_RST = 6'h12;
  // control bit: last-bit tx event select
  localparam int UIL_CTL_EOT = 0;
  // fifo and time-out
  localparam int UIL_FIFO_DEPTH = 16;
  localparam int UIL_CNT_W = 5;
  localparam int UIL_RTO_BITS = 32;
  localparam logic [UIL_CNT_W:0] UIL_RTO_LAST = 6'h1f;
  typedef logic [UIL_NEV-1:0] uil_ev_type;
endpackage

// ---- src/uil_lvl_if.sv ----
// interface: fifo level compare request and result between top and comparator
`timescale 1ns/1ps
interface uil_lvl_if;
  logic [uil_pkg::UIL_CNT_W-1:0] tx_count;
  logic [uil_pkg::UIL_CNT_W-1:0] rx_count;
  logic [uil_pkg::UIL_LVL_W-1:0] tx_level_select;
  logic [uil_pkg::UIL_LVL_W-1:0] rx_level_select;
  logic tx_hit;
  logic rx_hit;
  modport top (output tx_count, rx_count, tx_level_select, rx_level_select,
               input tx_hit, rx_hit);
  modport cmp (input tx_count, rx_count, tx_level_select, rx_level_select,
               output tx_hit, rx_hit);
endinterface

// ---- src/uil_level_cmp.sv ----
// fifo level comparator producing the tx and rx trigger conditions
`timescale 1ns/1ps
module uil_level_cmp (
  // level compare channel
  uil_lvl_if.cmp lv
);
  import uil_pkg::*;

  // threshold in entries: 1/8,1/4,1/2,3/4,7/8 of the fifo depth
  function automatic logic [UIL_CNT_W-1:0] uil_thr(input logic [UIL_LVL_W-1:0] sel);
    logic [UIL_CNT_W-1:0] t;
    t = UIL_CNT_W'(UIL_FIFO_DEPTH / 2);
    case (sel)
      3'h0: t = UIL_CNT_W'(UIL_FIFO_DEPTH / 8);
      3'h1: t = UIL_CNT_W'(UIL_FIFO_DEPTH / 4);
      3'h2: t = UIL_CNT_W'(UIL_FIFO_DEPTH / 2);
      3'h3: t = UIL_CNT_W'((UIL_FIFO_DEPTH * 3) / 4);
      3'h4: t = UIL_CNT_W'((UIL_FIFO_DEPTH * 7) / 8);
      default: t = UIL_CNT_W'(UIL_FIFO_DEPTH / 2);
    endcase
    return t;
  endfunction

  // tx fires at or below its threshold, rx at or above
  always_comb begin
    lv.tx_hit = (lv.tx_count <= uil_thr(lv.tx_level_select));
    lv.rx_hit = (lv.rx_count >= uil_thr(lv.rx_level_select));
  end
endmodule

// ---- src/uil_top.sv ----
// uart interrupt status, mask, clear and combined request with apb access
// What this block does
// - separate events for overrun, break, parity, framing, time-out, transmit, receive.
// - with last-bit select clear, transmit event follows tx fifo level condition.
// - with last-bit select set, transmit event fires when serializer goes empty.
// - receive event fires when rx fifo fill meets selected level condition.
// - all enabled events are ORed onto one interrupt request line.
// - masked status register reads raw status AND mask.
// - an event reaches the request only when its mask bit is set.
// - raw status always readable regardless of mask.
// - writing one to a clear bit clears raw and masked status, except when the event sets again in that same cycle.
// - time-out fires when rx fifo holds data and 32 bit periods pass idle.
// - time-out clears when rx fifo empties, holding read, or clear written.
// - fifos are sixteen entries deep; their levels drive tx and rx events.
// - framing event raised when stop bit sampled low.
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module uil_top #(
  parameter int FIFO_DEPTH = uil_pkg::UIL_FIFO_DEPTH
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fifo levels and serializer state from the uart
  input wire logic [uil_pkg::UIL_CNT_W-1:0] tx_fifo_count,
  input wire logic [uil_pkg::UIL_CNT_W-1:0] rx_fifo_count,
  input wire logic tx_shifter_busy,
  // receiver error pulses, one per character
  input wire logic rx_overrun,
  input wire logic rx_break,
  input wire logic rx_parity_err,
  input wire logic rx_stop_bit_low,
  // receive activity
  input wire logic rx_char_done,
  input wire logic rx_holding_read,
  input wire logic bit_tick,
  // combined interrupt request
  output logic irq
);
  import uil_pkg::*;

  typedef struct packed {
    uil_ev_type raw;
    uil_ev_type mask;
    logic [2*UIL_LVL_W-1:0] lvl;
    logic eot_sel;
    logic tx_hit_d;
    logic rx_hit_d;
    logic busy_d;
    logic [UIL_CNT_W:0] idle_cnt;
    logic [31:0] rdata;
  } uil_state_type;

  uil_state_type st_r;
  uil_state_type st_nxt;
  uil_ev_type set_ev;
  uil_ev_type clr_ev;
  uil_ev_type mis;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic tx_cond;
  logic rx_empty;
  logic tx_all_done;

  uil_lvl_if lv ();

  // level thresholds in a separate comparator
  assign lv.tx_count = tx_fifo_count;
  assign lv.rx_count = rx_fifo_count;
  assign lv.tx_level_select = st_r.lvl[UIL_TXL_LSB +: UIL_LVL_W];
  assign lv.rx_level_select = st_r.lvl[UIL_RXL_LSB +: UIL_LVL_W];

  uil_level_cmp u_cmp (
    .lv(lv.cmp)
  );

  // apb decode: zero wait states, access phase completes at once
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr[7:0] == UIL_OFS_RAW) || (paddr[7:0] == UIL_OFS_MASK) ||
                  (paddr[7:0] == UIL_OFS_MIS) || (paddr[7:0] == UIL_OFS_CLR) ||
                  (paddr[7:0] == UIL_OFS_LVL) || (paddr[7:0] == UIL_OFS_CTL);
  assign pslverr = psel & penable & ~mapped;
  assign prdata = st_r.rdata;

  // masked view and combined line
  assign mis = st_r.raw & st_r.mask;
  assign irq = |mis;

  assign rx_empty = (rx_fifo_count == '0);
  // serializer done: fifo empty and shifter falls idle
  assign tx_all_done = (tx_fifo_count == '0) & st_r.busy_d & ~tx_shifter_busy;
  // level events are edge-triggered so a clear sticks until the level is crossed again
  assign tx_cond = st_r.eot_sel ? tx_all_done : (lv.tx_hit & ~st_r.tx_hit_d);

  always_comb begin
    st_nxt = st_r;
    set_ev = '0;
    clr_ev = '0;
    // event sources, one bit each
    set_ev[UIL_B_OE] = rx_overrun;
    set_ev[UIL_B_BE] = rx_break;
    set_ev[UIL_B_PE] = rx_parity_err;
    set_ev[UIL_B_FE] = rx_stop_bit_low;
    set_ev[UIL_B_TX] = tx_cond;
    set_ev[UIL_B_RX] = lv.rx_hit & ~st_r.rx_hit_d & ~rx_empty;
    set_ev[UIL_B_RTO] = 1'b0;
    st_nxt.tx_hit_d = lv.tx_hit;
    st_nxt.rx_hit_d = lv.rx_hit & ~rx_empty;
    st_nxt.busy_d = tx_shifter_busy | (tx_fifo_count != '0);
    // idle counter runs only while data waits; a new char restarts it
    if (rx_empty || rx_char_done || rx_holding_read) begin
      st_nxt.idle_cnt = '0;
    end else if (bit_tick && (st_r.idle_cnt != UIL_RTO_LAST + 1'b1)) begin
      st_nxt.idle_cnt = st_r.idle_cnt + 1'b1;
      if (st_r.idle_cnt == UIL_RTO_LAST) begin
        set_ev[UIL_B_RTO] = 1'b1;
      end
    end
    // time-out drops by emptying or holding read
    if (rx_empty || rx_holding_read) begin
      clr_ev[UIL_B_RTO] = 1'b1;
    end
    // register writes
    if (wr_en) begin
      case (paddr[7:0])
        UIL_OFS_MASK: st_nxt.mask = pwdata[UIL_NEV-1:0];
        UIL_OFS_CLR: clr_ev = clr_ev | pwdata[UIL_NEV-1:0];
        UIL_OFS_LVL: st_nxt.lvl = pwdata[2*UIL_LVL_W-1:0];
        UIL_OFS_CTL: st_nxt.eot_sel = pwdata[UIL_CTL_EOT];
        default: st_nxt.mask = st_r.mask;
      endcase
    end
    // set wins over clear
    st_nxt.raw = (st_r.raw & ~clr_ev) | set_ev;
    // read data captured in the setup phase
    if (rd_en) begin
      case (paddr[7:0])
        UIL_OFS_RAW: st_nxt.rdata = 32'(st_r.raw);
        UIL_OFS_MASK: st_nxt.rdata = 32'(st_r.mask);
        UIL_OFS_MIS: st_nxt.rdata = 32'(mis);
        UIL_OFS_LVL: st_nxt.rdata = 32'(st_r.lvl);
        UIL_OFS_CTL: st_nxt.rdata = 32'(st_r.eot_sel);
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{raw: '0, mask: '0, lvl: UIL_LVL_RST, eot_sel: 1'b0, tx_hit_d: 1'b0,
                rx_hit_d: 1'b0, busy_d: 1'b0, idle_cnt: '0, rdata: 32'h0000_0000};
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// ---- testbench/uil_sva.sv ----
// checker: apb and request line relations at the uart interrupt block ports
`timescale 1ns/1ps
module uil_sva (
  // clock, reset and apb
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [31:0] paddr, pwdata, prdata,
  // receiver error pulses and request
  input wire logic rx_overrun, rx_break, rx_parity_err, rx_stop_bit_low, irq
);
  import uil_pkg::*;
  logic [6:0] mask_r;
  logic acc, rd_acc, wr_mask, hit;
  // a shadow of the mask is the only way to predict irq from the ports
  assign acc = psel & penable;
  assign rd_acc = acc & ~pwrite;
  assign wr_mask = acc & pwrite & (paddr[7:0] == UIL_OFS_MASK);
  assign hit = |({rx_overrun, rx_break, rx_parity_err, rx_stop_bit_low} & mask_r[6:3]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mask_r <= 7'h00;
    else if (wr_mask) mask_r <= pwdata[6:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_high: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (acc && paddr[7:0] > UIL_OFS_CTL |-> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && paddr[7:0] <= UIL_OFS_CTL && paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped access refused");
  a_slverr_setup: assert property (!penable |-> !pslverr) else $error("error outside access");
  a_masked_quiet: assert property (mask_r == 7'h00 |-> !irq) else $error("irq with mask clear");
  a_event_irq: assert property (hit && !wr_mask |=> irq) else $error("event missed irq");
  a_mis_empty: assert property (rd_acc && paddr[7:0] == UIL_OFS_MIS && mask_r == 7'h00 |-> prdata == 32'h0) else $error("masked status not gated");
  a_mask_back: assert property (rd_acc && paddr[7:0] == UIL_OFS_MASK |-> prdata == {25'h0, mask_r}) else $error("mask readback wrong");
endmodule
bind uil_top uil_sva u_sva (.*);

// ---- testbench/uil_uart_model.sv ----
// model: uart receive fifo fill and free running bit period ticks
`timescale 1ns/1ps
module uil_uart_model #(parameter int TICK_DIV = 4) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // character arrival and holding read
  input wire logic push,
  input wire logic pop,
  // toward the interrupt block
  output logic [4:0] rx_count,
  output logic bit_tick
);
  logic [3:0] div_r;
  // fill saturates at sixteen so the block never sees an impossible level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_count <= 5'h00;
      div_r <= 4'h0;
    end else begin
      div_r <= (div_r == 4'(TICK_DIV - 1)) ? 4'h0 : div_r + 4'h1;
      if (push && rx_count < 5'h10) rx_count <= rx_count + 5'h01;
      else if (pop && rx_count != 5'h00) rx_count <= rx_count - 5'h01;
    end
  end
  assign bit_tick = (div_r == 4'h0);
endmodule

// ---- testbench/uart_interrupt_logic_test.sv ----
// testbench: events, mask, clear, time-out and transmit select through apb
`timescale 1ns/1ps
module uart_interrupt_logic_test;
  import uil_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, busy, push, pop, tick, irq, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [4:0] txc, rxc;
  logic [3:0] err;
  int fail_count = 0;
  int checks_done = 0;
  logic [31:0] rows [4] = '{32'h40, 32'h20, 32'h10, 32'h08};
  uil_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_fifo_count(txc), .rx_fifo_count(rxc), .tx_shifter_busy(busy),
    .rx_overrun(err[3]), .rx_break(err[2]), .rx_parity_err(err[1]), .rx_stop_bit_low(err[0]),
    .rx_char_done(push), .rx_holding_read(pop), .bit_tick(tick), .irq(irq));
  uil_uart_model u_uart (.pclk(pclk), .presetn(presetn), .push(push), .pop(pop),
    .rx_count(rxc), .bit_tick(tick));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic pulse(input logic [3:0] v, input logic p);
    err <= v;
    push <= p;
    @(posedge pclk);
    err <= 4'h0;
    push <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    wrap_up();
  end
  initial begin
    {psel, penable, pwrite, busy, push, pop, presetn} = 7'h00;
    {paddr, pwdata, err, txc} = {64'h0, 4'h0, 5'h0a};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, UIL_OFS_LVL, 0);
    chk(rd, 32'h12);
    // each error source alone: raise, report masked, clear
    foreach (rows[i]) begin
      apb(1, UIL_OFS_MASK, rows[i]);
      pulse(rows[i][6:3], 0);
      chk({31'h0, irq}, 32'h1);
      apb(0, UIL_OFS_MIS, 0);
      chk(rd, rows[i]);
      apb(1, UIL_OFS_CLR, rows[i]);
      apb(0, UIL_OFS_RAW, 0);
      chk(rd & 32'h78, 32'h0);
    end
    // masked event stays raw only; a zero clear leaves it
    apb(1, UIL_OFS_MASK, 0);
    pulse(4'h8, 0);
    chk({31'h0, irq}, 32'h0);
    apb(1, UIL_OFS_CLR, 0);
    apb(0, UIL_OFS_RAW, 0);
    chk(rd & 32'h40, 32'h40);
    apb(1, UIL_OFS_CLR, 32'h7f);
    apb(0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    // one character then silence: time-out near 32 ticks of four cycles
    pulse(4'h0, 1);
    repeat (90) @(posedge pclk);
    apb(0, UIL_OFS_RAW, 0);
    chk(rd & 32'h4, 32'h0);
    repeat (50) @(posedge pclk);
    apb(0, UIL_OFS_RAW, 0);
    chk(rd & 32'h4, 32'h4);
    pop <= 1'b1;
    @(posedge pclk);
    pop <= 1'b0;
    apb(0, UIL_OFS_RAW, 0);
    chk(rd & 32'h4, 32'h0);
    repeat (8) pulse(4'h0, 1);
    txc <= 5'h04;
    // let the level edge register before the read setup captures raw
    @(posedge pclk);
    apb(0, UIL_OFS_RAW, 0);
    chk(rd & 32'h3, 32'h3);
    // last-bit select: nothing until the serializer goes idle
    apb(1, UIL_OFS_CLR, 32'h7f);
    apb(1, UIL_OFS_CTL, 32'h1);
    busy <= 1'b1;
    txc <= 5'h00;
    apb(0, UIL_OFS_RAW, 0);
    chk(rd & 32'h2, 32'h0);
    busy <= 1'b0;
    // idle edge sets the event; read data is captured one edge later
    @(posedge pclk);
    apb(0, UIL_OFS_RAW, 0);
    chk(rd & 32'h2, 32'h2);
    wrap_up();
  end
endmodule
